// [verilog/pmsi_defines.vh]
`ifndef PMSI_DEFINES_VH
`define PMSI_DEFINES_VH

// frame field widths
`define PMSI_PRE_LEN     6'h20
`define PMSI_DATA_W      6'h10
// opcodes
`define PMSI_OP_WRITE    2'h1
`define PMSI_OP_READ     2'h2
// register addresses
`define PMSI_REG_CTRL    5'h00
`define PMSI_REG_STAT    5'h01
`define PMSI_REG_IMASK   5'h12
`define PMSI_REG_ISTAT   5'h13
// reset values
`define PMSI_CTRL_RST    16'h0000
`define PMSI_IMASK_RST   16'h0000
`define PMSI_ISTAT_RST   16'h0000
// management clock limit, ns period
`define PMSI_MDC_MIN_NS  400

`endif

// [verilog/pmsi_sync.v]
`timescale 1ns/10ps
`default_nettype none
module pmsi_sync (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        din,
    output wire        dout
);
    reg stage1;
    reg stage2;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end
    assign dout = stage2;
endmodule
`default_nettype wire

// [verilog/pmsi_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "pmsi_defines.vh"
module pmsi_top (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        mdc,
    input  wire        mdio_i,
    output reg         mdio_o,
    output reg         mdio_oe,
    output reg         irq_o,
    output reg         irq_oe,
    input  wire [4:0]  phy_addr,
    input  wire [15:0] event_in,
    input  wire [15:0] status_in,
    output reg  [15:0] ctrl_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_HEAD = 3'h1;
    localparam ST_TA   = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_RDAT = 3'h4;

    wire mdc_s;
    wire mdio_s;
    wire [15:0] ev_s;
    reg  [15:0] ev_d;
    reg         mdc_d;
    reg  [2:0]  state;
    reg  [5:0]  cnt;
    // second start bit ends up in bit 12
    reg  [12:0] head;
    reg  [15:0] shreg;
    reg  [15:0] imask;
    reg  [15:0] istat;
    reg         hit;
    reg  [4:0]  raddr;

    // rule 2: all pins sampled into sys_clk, no MAC clock involved
    // own clock domain
    pmsi_sync u_mdc (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .din     (mdc),
        .dout    (mdc_s)
    );
    pmsi_sync u_mdio (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .din     (mdio_i),
        .dout    (mdio_s)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_ev
            pmsi_sync u_ev (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .din     (event_in[gi]),
                .dout    (ev_s[gi])
            );
        end
    endgenerate

    wire rise = mdc_s & ~mdc_d;
    wire fall = ~mdc_s & mdc_d;
    wire [12:0] nhead = {head[11:0], mdio_s};
    wire [15:0] ev_rise = ev_s & ~ev_d;
    // clear in the very cycle the cause word is captured into shreg,
    // so an event between capture and clear is never lost
    wire rd_istat = (state == ST_TA) && hit && (head[11:10] == `PMSI_OP_READ)
                    && (raddr == `PMSI_REG_ISTAT) && fall && (cnt == 6'h01);

    function [15:0] rd_mux;
        input [4:0] a;
        begin
            if (a == `PMSI_REG_CTRL)
                rd_mux = ctrl_out;
            else if (a == `PMSI_REG_STAT)
                rd_mux = status_in;
            else if (a == `PMSI_REG_IMASK)
                rd_mux = imask;
            else if (a == `PMSI_REG_ISTAT)
                rd_mux = istat;
            else
                rd_mux = 16'h0000;
        end
    endfunction

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mdc_d    <= 1'b0;
            ev_d     <= 16'h0000;
            state    <= ST_IDLE;
            cnt      <= 6'h00;
            head     <= 13'h0000;
            shreg    <= 16'h0000;
            hit      <= 1'b0;
            raddr    <= 5'h00;
            mdio_o   <= 1'b0;
            mdio_oe  <= 1'b0;
            ctrl_out <= `PMSI_CTRL_RST;
            imask    <= `PMSI_IMASK_RST;
        end else begin
            mdc_d <= mdc_s;
            ev_d  <= ev_s;
            case (state)
                ST_IDLE: begin
                    if (rise) begin
                        if (mdio_s)
                            cnt <= (cnt == 6'h3f) ? cnt : cnt + 6'h01;
                        else if (cnt >= `PMSI_PRE_LEN) begin
                            state <= ST_HEAD;
                            cnt   <= 6'h00;
                            head  <= 13'h0000;
                        end else
                            cnt <= 6'h00;
                    end
                end
                ST_HEAD: begin
                    // start second bit plus 2 op + 5 phy + 5 reg bits
                    if (rise) begin
                        head <= nhead;
                        cnt  <= cnt + 6'h01;
                        if (cnt == 6'h0c) begin
                            hit   <= (nhead[12] == 1'b1) && (nhead[9:5] == phy_addr)
                                     && ((nhead[11:10] == `PMSI_OP_READ)
                                     || (nhead[11:10] == `PMSI_OP_WRITE));
                            raddr <= nhead[4:0];
                            state <= ST_TA;
                            cnt   <= 6'h00;
                        end
                    end
                end
                ST_TA: begin
                    if (rise) begin
                        cnt <= cnt + 6'h01;
                        if (cnt == 6'h01) begin
                            cnt <= 6'h00;
                            state <= (head[11:10] == `PMSI_OP_READ) ? ST_RDAT : ST_WDAT;
                        end
                    end
                    // drive 0 in second turnaround bit on read
                    if (fall && hit && head[11:10] == `PMSI_OP_READ) begin
                        if (cnt == 6'h01) begin
                            mdio_oe <= 1'b1;
                            mdio_o  <= 1'b0;
                            shreg   <= rd_mux(raddr);
                        end
                    end
                end
                ST_WDAT: begin
                    if (rise) begin
                        shreg <= {shreg[14:0], mdio_s};
                        cnt   <= cnt + 6'h01;
                        if (cnt == 6'h0f) begin
                            state <= ST_IDLE;
                            cnt   <= 6'h00;
                            if (hit && raddr == `PMSI_REG_CTRL)
                                ctrl_out <= {shreg[14:0], mdio_s};
                            else if (hit && raddr == `PMSI_REG_IMASK)
                                imask <= {shreg[14:0], mdio_s};
                        end
                    end
                end
                ST_RDAT: begin
                    // device drives from the second turnaround bit through the end of read data
                    if (fall) begin
                        if (cnt == `PMSI_DATA_W) begin
                            mdio_oe <= 1'b0;
                            mdio_o  <= 1'b0;
                            state   <= ST_IDLE;
                            cnt     <= 6'h00;
                        end else begin
                            // output stays low when another device is addressed
                            mdio_o <= hit ? shreg[15] : 1'b0;
                            shreg  <= {shreg[14:0], 1'b0};
                            cnt    <= cnt + 6'h01;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // sticky cause bits, set beats read-clear
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            istat <= `PMSI_ISTAT_RST;
        else if (rd_istat)
            istat <= ev_rise;
        else
            istat <= istat | ev_rise;
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_o  <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            irq_o  <= 1'b0;
            irq_oe <= |(istat & imask);
        end
    end
endmodule
`default_nettype wire

// [verif/pmsi_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module pmsi_top_assertions (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        mdc,
    input wire logic        mdio_o,
    input wire logic        mdio_oe,
    input wire logic        irq_o,
    input wire logic        irq_oe,
    input wire logic [15:0] ctrl_out
);
    logic       mdc_q;
    logic [5:0] idle;
    // cycles since the clock line last moved
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mdc_q <= 1'b0;
            idle  <= 6'h3f;
        end else begin
            mdc_q <= mdc;
            idle  <= (mdc != mdc_q) ? 6'h00 : ((idle == 6'h3f) ? idle : idle + 6'h01);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_irq_low; irq_o == 1'b0; endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt line driven high");
    property p_idle_release; idle > 6'h0c |-> !mdio_oe; endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data line driven outside a frame");
    property p_quiet_data; !mdio_oe |-> !mdio_o; endproperty
    a_quiet_data: assert property (p_quiet_data)
        else $error("data output moves while released");
    property p_bit_stands; mdio_oe && $changed(mdio_o) |=> $stable(mdio_o)[*5]; endproperty
    a_bit_stands: assert property (p_bit_stands)
        else $error("read bit shorter than a clock period");
    property p_oe_span; $rose(mdio_oe) |-> mdio_oe[*8]; endproperty
    a_oe_span: assert property (p_oe_span)
        else $error("read drive ended too soon");
    property p_irq_clear; $fell(irq_oe) |-> idle < 6'h0c; endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt cleared without a frame");
    property p_ctrl_upd; $changed(ctrl_out) |-> idle < 6'h08; endproperty
    a_ctrl_upd: assert property (p_ctrl_upd)
        else $error("control changed away from a clock edge");
endmodule
bind pmsi_top pmsi_top_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst), .mdc(mdc),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .irq_o(irq_o), .irq_oe(irq_oe), .ctrl_out(ctrl_out));
`default_nettype wire

// [verif/pmsi_station.sv]
`timescale 1ns/10ps
`default_nettype none
module pmsi_station (
    input  wire logic        sys_clk,
    input  wire logic        line,
    output logic             mdc,
    output logic             st_o,
    output logic             st_oe,
    output logic [15:0]      rd_data,
    output logic             rd_stb
);
    initial begin
        mdc = 1'b0; st_o = 1'b1; st_oe = 1'b0; rd_data = 16'h0000; rd_stb = 1'b0;
    end
    task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd);
        logic [63:0] fr;
        fr = {32'hffffffff, 2'h1, rd ? 2'h2 : 2'h1, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            @(negedge sys_clk);
            mdc = 1'b0; st_oe = !(rd && i < 18); st_o = fr[i];
            repeat (4) @(negedge sys_clk);
            mdc = 1'b1;
            repeat (3) @(negedge sys_clk);
            if (i < 16) rd_data[i] = line;
        end
        // closing fall, then clock stands still
        @(negedge sys_clk);
        mdc = 1'b0; st_oe = 1'b0;
        repeat (8) @(negedge sys_clk);
        rd_stb = rd;
        @(negedge sys_clk);
        rd_stb = 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/test_phy_mgmt_serial_irq.sv]
`timescale 1ns/10ps
`default_nettype none
module test_phy_mgmt_serial_irq;
    localparam logic [4:0] ADDR = 5'h0b;
    logic        sys_clk, nrst, mdc, st_o, st_oe, rd_stb, mdio_o, mdio_oe, irq_o, irq_oe;
    logic [15:0] event_in, status_in, ctrl_out, rd_data, val;
    logic [15:0] exp_q[$];
    int          bad_count, cmp_count, seed;
    wire         line = mdio_oe ? mdio_o : (st_oe ? st_o : 1'b1);
    pmsi_top DUT (.sys_clk(sys_clk), .nrst(nrst), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .irq_o(irq_o), .irq_oe(irq_oe), .phy_addr(ADDR),
        .event_in(event_in), .status_in(status_in), .ctrl_out(ctrl_out));
    pmsi_station st (.sys_clk(sys_clk), .line(line), .mdc(mdc), .st_o(st_o), .st_oe(st_oe),
        .rd_data(rd_data), .rd_stb(rd_stb));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        exp_q.push_back(e);
        st.xfer(1'b1, ADDR, ra, 16'h0000);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d compares %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge rd_stb) chk(rd_data, exp_q.pop_front());
    initial begin
        #2000000;
        bad_count++;
        end_of_test;
    end
    initial begin
        seed = 71; nrst = 1'b0; event_in = 16'h0000; status_in = 16'h0000;
        bad_count = 0; cmp_count = 0;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({14'h0000, irq_oe, mdio_oe}, 16'h0000);
        val = $random(seed);
        status_in = $random(seed);
        st.xfer(1'b0, ADDR, 5'h00, val);
        chk(ctrl_out, val);
        rd(5'h00, val);
        st.xfer(1'b0, ~ADDR, 5'h00, ~val);
        chk(ctrl_out, val);
        exp_q.push_back(16'hffff);
        st.xfer(1'b1, ~ADDR, 5'h00, 16'h0000);
        rd(5'h01, status_in);
        rd(5'h05, 16'h0000);
        st.xfer(1'b0, ADDR, 5'h12, 16'h0001);
        event_in = 16'h0002;
        repeat (10) @(negedge sys_clk);
        chk({15'h0000, irq_oe}, 16'h0000);
        event_in = 16'h0003;
        repeat (10) @(negedge sys_clk);
        chk({15'h0000, irq_oe}, 16'h0001);
        rd(5'h13, 16'h0003);
        chk({15'h0000, irq_oe}, 16'h0000);
        rd(5'h13, 16'h0000);
        end_of_test;
    end
endmodule
`default_nettype wire
